// file: verilog/pmt_pkg.sv
// Constants, field layouts and carrier types of the pulse measurement timer
package pmt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [15:0] ADDR_CTRL = 16'h0100;
  localparam logic [15:0] ADDR_IOC = 16'h0101;
  localparam logic [15:0] ADDR_MODE = 16'h0102;
  localparam logic [15:0] ADDR_PRE = 16'h0103;
  localparam logic [15:0] ADDR_CNT = 16'h0104;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STATUS = 1;
  localparam int CTRL_FSTOP = 2;
  localparam int CTRL_EDGE = 4;
  localparam int CTRL_UNDF = 5;
  localparam int IOC_POL = 0;
  localparam int IOC_FILT = 4;
  localparam int MODE_POS = 0;
  localparam int CSRC_POS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_PRE = 8'hFF;
  localparam logic [7:0] RST_CNT = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts
  localparam int FILT_SAMPLES = 3;
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV2_MASK = 5'h01;
  localparam logic [DIV_W-1:0] DIV8_MASK = 5'h07;
  localparam logic [DIV_W-1:0] DIV32_MASK = 5'h1F;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [2:0] {
    MODE_TIMER = 3'b000,
    MODE_WIDTH = 3'b011,
    MODE_PERIOD = 3'b100
  } pmt_mode_type;

  typedef enum logic [2:0] {
    CS_F1 = 3'b000,
    CS_F8 = 3'b001,
    CS_OSC = 3'b010,
    CS_F2 = 3'b011,
    CS_SUB32 = 3'b100,
    CS_SUB = 3'b101
  } pmt_csrc_type;

  typedef enum logic [1:0] {
    FILT_NONE = 2'b00,
    FILT_F1 = 2'b01,
    FILT_F8 = 2'b10,
    FILT_F32 = 2'b11
  } pmt_filt_type;

  typedef enum logic [1:0] {
    PST_IDLE = 2'b00,
    PST_WAIT1 = 2'b01,
    PST_WAIT2 = 2'b10
  } pmt_pst_type;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pmt_bus_type;

  typedef struct packed {
    logic f1;
    logic f2;
    logic f8;
    logic f32;
    logic osc;
    logic sub;
    logic sub32;
  } pmt_tick_type;

endpackage

// file: verilog/pmt_clk_src.sv
// Count source and sampling tick generator of the pulse measurement timer
`timescale 1ns/10ps
module pmt_clk_src import pmt_pkg::*; (
  // Clock and reset
  input logic ref_clk,
  input logic nrst,
  input logic clk_en,
  // Foreign clocks, sampled as levels
  input logic onchip_osc_clock,
  input logic subclock,
  // One-cycle ticks
  output pmt_tick_type ticks
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [2:0] osc_s;
    logic [2:0] sub_s;
    logic [DIV_W-1:0] sub_div;
    pmt_tick_type t;
  } pmt_src_state_type;

  pmt_src_state_type q;
  pmt_src_state_type n;
  logic osc_rise;
  logic sub_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: free divider and edge detection on synchronised clocks
  always_comb begin
    n = q;
    n.div = q.div + 5'h01;
    // Stage 0 feeds only stage 1; edges compare stages 1 and 2
    n.osc_s = {q.osc_s[1:0], onchip_osc_clock};
    n.sub_s = {q.sub_s[1:0], subclock};
    osc_rise = q.osc_s[1] & ~q.osc_s[2];
    sub_rise = q.sub_s[1] & ~q.sub_s[2];
    if (sub_rise) begin
      n.sub_div = q.sub_div + 5'h01;
    end
    n.t.f1 = 1'b1;
    n.t.f2 = (q.div & DIV2_MASK) == DIV2_MASK;
    n.t.f8 = (q.div & DIV8_MASK) == DIV8_MASK;
    n.t.f32 = (q.div & DIV32_MASK) == DIV32_MASK;
    n.t.osc = osc_rise;
    n.t.sub = sub_rise;
    n.t.sub32 = sub_rise & (q.sub_div == DIV32_MASK);
  end

  // Registered state, frozen while the clock enable is low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= n;
    end
  end

  assign ticks = q.t;

endmodule

// file: verilog/pmt_in_filter.sv
// Synchroniser and three-sample digital filter for the measured input
`timescale 1ns/10ps
module pmt_in_filter import pmt_pkg::*; (
  // Clock and reset
  input logic ref_clk,
  input logic nrst,
  input logic clk_en,
  // Raw pin and filter control
  input logic measure_io_pin,
  input logic [1:0] filt_sel,
  input pmt_tick_type ticks,
  // Accepted level
  output logic level
);

  typedef struct packed {
    logic [1:0] sync;
    logic [FILT_SAMPLES-1:0] smp;
    logic lvl;
  } pmt_flt_state_type;

  pmt_flt_state_type q;
  pmt_flt_state_type n;
  logic smp_tick;
  logic [FILT_SAMPLES-1:0] smp_new;

  // True when every sample agrees
  function automatic logic all_same(input logic [FILT_SAMPLES-1:0] v);
    all_same = (v == '0) || (v == '1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sampling rate select and level acceptance
  always_comb begin
    n = q;
    n.sync = {q.sync[0], measure_io_pin};
    case (filt_sel)
      FILT_F1: smp_tick = ticks.f1; // RQ4
      FILT_F8: smp_tick = ticks.f8; // RQ4
      FILT_F32: smp_tick = ticks.f32; // RQ4
      default: smp_tick = 1'b0;
    endcase
    smp_new = {q.smp[FILT_SAMPLES-2:0], q.sync[1]};
    if (filt_sel == FILT_NONE) begin
      n.lvl = q.sync[1]; // RQ4
    end else if (smp_tick) begin
      n.smp = smp_new;
      // Noise shorter than three samples never reaches the counter
      if (all_same(smp_new)) begin
        n.lvl = smp_new[0]; // RQ5
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= n;
    end
  end

  assign level = q.lvl;

  AST_FILTER_THREE: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ5
    (filt_sel != FILT_NONE) && $changed(q.lvl) |-> all_same($past(smp_new)))
    else $error("filtered level changed without three equal samples");

endmodule

// file: verilog/pmt_timer.sv
// Pulse width and pulse period measurement timer with register port
// Notes on behaviour
// [RQ1] Width mode polarity: 0 low, 1 high
// [RQ2] Width mode counts only at selected level
// [RQ3] Period mode polarity: 0 rising, 1 falling
// [RQ4] Filter off, or sampling f1, f8, f32
// [RQ5] Level accepted after three equal samples
// [RQ6] Count source f1, f2, f8, oscillator, subclocks
// [RQ7] Latch at first, reload at second underflow
// [RQ8] Request on underflow, reload, period end
// [RQ9] Start bit runs; forced stop halts now
// [RQ10] Writes load reload register and counter
// [RQ11] Source keeps widths above prescaler period
// [RQ12] Edge flag set at second prescaler underflow
// [RQ13] Counter read gives buffer; unread keeps old
// [RQ14] Flags clear on 0, unchanged on 1
// [RQ15] Simultaneous underflow and reload set both
// [RQ16] Stopped after reset
// [RQ17] Prescaler and counter read bytewise
// [RQ18] Software clears flags entering period mode
// [RQ19] Software waits two prescaler periods first
// [RQ20] Status follows start within one source cycle
// [RQ21] Status drops within one source cycle
// [RQ22] Software spaces running writes three cycles
// [RQ23] Software keeps unused control bits zero
`timescale 1ns/10ps
module pmt_timer import pmt_pkg::*; (
  // Clock, reset and freeze
  input logic ref_clk,
  input logic nrst,
  input logic clk_en,
  // Register port
  input pmt_bus_type bus_req,
  output logic [7:0] rd_data,
  // Pins and foreign clocks
  input logic measure_io_pin,
  input logic onchip_osc_clock,
  input logic subclock,
  // Status out
  output logic irq_req,
  output logic count_status
);

  typedef struct packed {
    logic start;
    logic status;
    logic edge_f;
    logic undf_f;
    logic [7:0] ioc;
    logic [2:0] mode;
    logic [2:0] csrc;
    logic [7:0] pre_rl;
    logic [7:0] pre_cnt;
    logic [7:0] cnt_rl;
    logic [7:0] cnt;
    logic [7:0] rbuf;
    logic rbuf_free;
    pmt_pst_type pst;
    logic lvl_prev;
    logic [7:0] rdata;
    logic irq;
  } pmt_state_type;

  pmt_state_type q;
  pmt_state_type n;
  pmt_tick_type ticks;
  logic level;
  logic cs_tick;
  logic run;
  logic cnt_en;
  logic pre_uf;
  logic cnt_zero;
  logic reload_now;
  logic rise;
  logic fall;
  logic act_edge;
  logic width_end;
  logic edge_set;
  logic undf_set;
  logic is_width;
  logic is_period;
  logic wr_ctrl;
  logic wr_pre;
  logic rd_cnt;

  // Down count by one
  function automatic logic [7:0] dec8(input logic [7:0] v);
    dec8 = v - 8'h01;
  endfunction

  // Pick the count source tick
  function automatic logic tick_sel(input logic [2:0] sel, input pmt_tick_type t);
    if (sel == CS_F1) begin
      tick_sel = t.f1;
    end else if (sel == CS_F2) begin
      tick_sel = t.f2;
    end else if (sel == CS_F8) begin
      tick_sel = t.f8;
    end else if (sel == CS_OSC) begin
      tick_sel = t.osc;
    end else if (sel == CS_SUB) begin
      tick_sel = t.sub;
    end else if (sel == CS_SUB32) begin
      tick_sel = t.sub32;
    end else begin
      tick_sel = 1'b0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Tick sources and input conditioning
  pmt_clk_src u_src (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .onchip_osc_clock(onchip_osc_clock),
    .subclock(subclock),
    .ticks(ticks)
  );

  pmt_in_filter u_flt (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .measure_io_pin(measure_io_pin),
    .filt_sel(q.ioc[IOC_FILT+1:IOC_FILT]),
    .ticks(ticks),
    .level(level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = q;
    n.irq = 1'b0;
    n.rdata = RST_BYTE;
    n.lvl_prev = level;
    is_width = q.mode == MODE_WIDTH;
    is_period = q.mode == MODE_PERIOD;
    wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_CTRL);
    wr_pre = bus_req.wr && (bus_req.addr == ADDR_PRE);
    rd_cnt = bus_req.rd && (bus_req.addr == ADDR_CNT);
    cs_tick = tick_sel(q.csrc, ticks); // RQ6
    // Status catches up with start on a source tick; a forced stop clears it at once
    if (cs_tick) begin
      n.status = q.start; // RQ20 RQ21
    end
    run = q.status && cs_tick; // RQ20 RQ21
    rise = level && !q.lvl_prev;
    fall = !level && q.lvl_prev;
    // Width mode counts only while the pin sits at the chosen level
    cnt_en = run && (!is_width || (level == q.ioc[IOC_POL])); // RQ1 RQ2
    width_end = q.status && is_width && (q.ioc[IOC_POL] ? fall : rise);
    act_edge = q.status && is_period && (q.ioc[IOC_POL] ? fall : rise); // RQ3
    pre_uf = cnt_en && (q.pre_cnt == 8'h00);
    cnt_zero = q.cnt == 8'h00;
    reload_now = pre_uf && is_period && (q.pst == PST_WAIT2);
    undf_set = pre_uf && cnt_zero;
    edge_set = reload_now || width_end; // RQ12
    // Prescaler
    if (cnt_en) begin
      n.pre_cnt = (q.pre_cnt == 8'h00) ? q.pre_rl : dec8(q.pre_cnt);
    end
    // Main counter, reload on underflow or at the end of a period
    if (pre_uf) begin
      n.cnt = (cnt_zero || reload_now) ? q.cnt_rl : dec8(q.cnt); // RQ2 RQ7
    end
    // Period sequencer; edges during the wait are ignored
    case (q.pst)
      PST_IDLE: begin
        if (act_edge) begin
          n.pst = PST_WAIT1;
        end
      end
      PST_WAIT1: begin
        if (pre_uf) begin
          // An unread result is kept over the new one
          if (q.rbuf_free) begin
            n.rbuf = q.cnt; // RQ7 RQ13
            n.rbuf_free = 1'b0; // RQ13
          end
          n.pst = PST_WAIT2;
        end
      end
      PST_WAIT2: begin
        if (pre_uf) begin
          n.pst = PST_IDLE; // RQ7
        end
      end
      default: n.pst = PST_IDLE;
    endcase
    if (!is_period) begin
      n.pst = PST_IDLE;
    end
    // Request pulse
    n.irq = undf_set || reload_now || act_edge || width_end; // RQ8
    // Software writes
    if (wr_ctrl) begin
      n.start = bus_req.wdata[CTRL_START]; // RQ9
      if (!bus_req.wdata[CTRL_EDGE]) begin
        n.edge_f = 1'b0; // RQ14
      end
      if (!bus_req.wdata[CTRL_UNDF]) begin
        n.undf_f = 1'b0; // RQ14
      end
      if (bus_req.wdata[CTRL_FSTOP]) begin
        n.start = 1'b0; // RQ9
        n.status = 1'b0; // RQ9
        n.pst = PST_IDLE;
      end
    end else if (bus_req.wr && (bus_req.addr == ADDR_IOC)) begin
      n.ioc = bus_req.wdata;
    end else if (bus_req.wr && (bus_req.addr == ADDR_MODE)) begin
      n.mode = bus_req.wdata[MODE_POS+2:MODE_POS];
      n.csrc = bus_req.wdata[CSRC_POS+2:CSRC_POS];
    end else if (wr_pre) begin
      n.pre_rl = bus_req.wdata; // RQ10
      n.pre_cnt = bus_req.wdata; // RQ10
    end else if (bus_req.wr && (bus_req.addr == ADDR_CNT)) begin
      n.cnt_rl = bus_req.wdata; // RQ10
      n.cnt = bus_req.wdata; // RQ10
    end
    // Hardware sets win over a clear in the same cycle
    if (edge_set) begin
      n.edge_f = 1'b1; // RQ12 RQ15
    end
    if (undf_set) begin
      n.undf_f = 1'b1; // RQ15
    end
    // Reads, one byte each, answered next cycle
    if (bus_req.rd) begin
      if (bus_req.addr == ADDR_CTRL) begin
        n.rdata = {2'b00, q.undf_f, q.edge_f, 2'b00, q.status, q.start};
      end else if (bus_req.addr == ADDR_IOC) begin
        n.rdata = q.ioc;
      end else if (bus_req.addr == ADDR_MODE) begin
        n.rdata = {1'b0, q.csrc, 1'b0, q.mode};
      end else if (bus_req.addr == ADDR_PRE) begin
        n.rdata = q.pre_cnt; // RQ17
      end else if (rd_cnt) begin
        n.rdata = is_period ? q.rbuf : q.cnt; // RQ13 RQ17
        if (is_period && !(q.pst == PST_WAIT1 && pre_uf)) begin
          n.rbuf_free = 1'b1; // RQ13
        end
      end else begin
        n.rdata = RST_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves the timer stopped
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0; // RQ16
      q.pre_rl <= RST_PRE;
      q.pre_cnt <= RST_PRE;
      q.cnt_rl <= RST_CNT;
      q.cnt <= RST_CNT;
      q.rbuf <= RST_CNT;
      q.rbuf_free <= 1'b1;
      q.pst <= PST_IDLE;
    end else if (clk_en) begin
      q <= n;
    end
  end

  assign rd_data = q.rdata;
  assign irq_req = q.irq;
  assign count_status = q.status;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_WIDTH_GATE: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ1
    clk_en && is_width && (level != q.ioc[IOC_POL]) && !wr_pre |=> $stable(q.pre_cnt))
    else $error("prescaler moved outside the measured level");

  AST_FORCED_STOP: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ9
    clk_en && wr_ctrl && bus_req.wdata[CTRL_FSTOP] |=> !q.start && !q.status)
    else $error("forced stop did not halt the count");

  AST_PRE_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ10
    clk_en && wr_pre |=> (q.pre_rl == $past(bus_req.wdata)) && (q.pre_cnt == q.pre_rl))
    else $error("prescaler write missed reload or counter");

  AST_FLAG_WRITE_ONE: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ14
    clk_en && q.edge_f && wr_ctrl && bus_req.wdata[CTRL_EDGE] |=> q.edge_f)
    else $error("writing one changed the edge flag");

  AST_SECOND_UF: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ12
    clk_en && (q.pst == PST_WAIT2) && pre_uf |=> q.edge_f && (q.pst == PST_IDLE))
    else $error("edge flag not set at second underflow");

  AST_BOTH_FLAGS: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ15
    clk_en && reload_now && cnt_zero |=> q.edge_f && q.undf_f)
    else $error("simultaneous underflow and reload lost a flag");

  AST_BUF_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ13
    !q.rbuf_free && !rd_cnt ##1 !q.rbuf_free |-> $stable(q.rbuf))
    else $error("unread result was overwritten");

  AST_STATUS_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ20
    clk_en && q.start && !q.status && cs_tick && !wr_ctrl |=> q.status)
    else $error("status did not follow start on a source tick");

  AST_UF_REQUEST: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ8
    clk_en && (undf_set || reload_now) |=> irq_req)
    else $error("no request on underflow or reload");

endmodule

// file: testbench/pmt_pulse_src.sv
// Model of the external pulse source on the measured pin
`timescale 1ns/10ps
module pmt_pulse_src (
  // Clock
  input wire logic ref_clk,
  // Control from the bench
  input wire logic run,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len,
  // Measured pin
  output logic pin
);
  logic [7:0] cnt_q;

  initial begin
    pin = 1'b0;
    cnt_q = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Square wave, high first; held low when idle so no stray edge appears
  always @(posedge ref_clk) begin
    if (!run) begin
      pin <= 1'b0;
      cnt_q <= 8'h00;
    end else if (cnt_q == 8'h00) begin
      pin <= !pin;
      cnt_q <= pin ? lo_len - 8'h01 : hi_len - 8'h01;
    end else begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

// file: testbench/tb_pmt_timer.sv
// Self-checking bench of the pulse measurement timer
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_pmt_timer import pmt_pkg::*; ;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic osc = 1'b0;
  logic sub = 1'b0;
  logic run = 1'b0;
  logic [7:0] hi_len = 8'h14;
  logic [7:0] lo_len = 8'h14;
  logic pin;
  pmt_bus_type bus = '0;
  logic [7:0] rd_data;
  logic irq_req;
  logic count_status;
  int checked = 0;
  int n_fail = 0;
  int n_irq = 0;
  int cycles = 0;
  logic [7:0] a, b, c;
  logic [1:0] ft [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  int fw [7] = '{2, 2, 5, 12, 40, 40, 120};
  int se [6] = '{202, 101, 25, 20, 34, 1};
  pmt_csrc_type sc [6] = '{CS_F1, CS_F2, CS_F8, CS_OSC, CS_SUB, CS_SUB32};

  pmt_timer u_dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .bus_req(bus),
    .rd_data(rd_data), .measure_io_pin(pin), .onchip_osc_clock(osc), .subclock(sub),
    .irq_req(irq_req), .count_status(count_status));

  pmt_pulse_src u_src (.ref_clk(ref_clk), .run(run), .hi_len(hi_len), .lo_len(lo_len),
    .pin(pin));

  ////////////////////////////////////////////////////////////////////////////
  // Clocks: main 125 MHz, slow oscillator and sub-clock as levels
  always #4 ref_clk = ~ref_clk;
  always begin
    repeat (5) @(posedge ref_clk);
    osc <= ~osc;
  end
  always begin
    repeat (3) @(posedge ref_clk);
    sub <= ~sub;
  end

  // Request counter and hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (irq_req === 1'b1) n_irq++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port tasks; each leaves one idle edge so strobes never collide
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    bus.addr <= ad;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [15:0] ad, output logic [7:0] v);
    bus.addr <= ad;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    v = rd_data;
    @(posedge ref_clk);
  endtask

  task automatic rc(input logic [15:0] ad, input logic [7:0] m, input logic [7:0] e,
    input string nm);
    logic [7:0] v;
    rd(ad, v);
    `CHK(nm, e, v & m)
  endtask

  // Stop, program, start, then clear flags after a fixed twelve-cycle wait
  task automatic setup(input logic [7:0] md, input logic [7:0] io, input logic [7:0] p);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, md);
    wr(ADDR_IOC, io);
    wr(ADDR_PRE, p);
    wr(ADDR_CNT, 8'h3F);
    wr(ADDR_CTRL, 8'h01);
    cyc(12);
    wr(ADDR_CTRL, 8'h01);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rc(ADDR_CTRL, 8'hFF, RST_BYTE, "ctrl");
    rc(ADDR_IOC, 8'hFF, RST_BYTE, "ioc");
    rc(ADDR_MODE, 8'hFF, RST_BYTE, "mode");
    rc(ADDR_PRE, 8'hFF, RST_PRE, "pre");
    rc(ADDR_CNT, 8'hFF, RST_CNT, "cnt");
    wr(16'h0105, 8'h5A);
    rc(16'h0105, 8'hFF, 8'h00, "unmapped");
    clk_en <= 1'b0;
    wr(ADDR_IOC, 8'h11);
    clk_en <= 1'b1;
    rc(ADDR_IOC, 8'hFF, 8'h00, "frozen write");
    wr(ADDR_IOC, 8'h31);
    rc(ADDR_IOC, 8'hFF, 8'h31, "ioc rw");
    wr(ADDR_PRE, 8'h03);
    wr(ADDR_CNT, 8'h05);
    rc(ADDR_PRE, 8'hFF, 8'h03, "pre load");
    rc(ADDR_CNT, 8'hFF, 8'h05, "cnt load");
    $display("test registers done");
    // Every count source against its expected tick count over the gap
    for (int i = 0; i < 6; i++) begin
      setup({1'b0, sc[i], 1'b0, MODE_TIMER}, 8'h00, 8'hFF);
      cyc(200);
      rd(ADDR_PRE, a);
      cyc(200);
      rd(ADDR_PRE, b);
      c = a - b;
      `CHK("source ticks", 1'b1, (int'(c) >= se[i] - 2) && (int'(c) <= se[i] + 2))
      rc(ADDR_CTRL, 8'h03, 8'h03, "running");
    end
    wr(ADDR_CTRL, 8'h00);
    cyc(200);
    rc(ADDR_CTRL, 8'h03, 8'h00, "stopped");
    $display("test sources done");
    // Status follows start within one f1 cycle, forced stop halts at once
    setup({1'b0, CS_F1, 1'b0, MODE_TIMER}, 8'h00, 8'h00);
    // Counter loaded with 3F needs 64 f1 ticks to underflow
    cyc(64);
    rc(ADDR_CTRL, 8'h20, 8'h20, "underflow flag");
    `CHK("irq seen", 1'b1, n_irq > 0)
    // Stop while writing one to keep the underflow flag
    wr(ADDR_CTRL, 8'h20);
    cyc(4);
    wr(ADDR_CTRL, 8'h20);
    rc(ADDR_CTRL, 8'h20, 8'h20, "undf kept");
    wr(ADDR_CTRL, 8'h10);
    rc(ADDR_CTRL, 8'h20, 8'h00, "undf cleared");
    wr(ADDR_CTRL, 8'h01);
    rc(ADDR_CTRL, 8'h03, 8'h03, "status one cycle");
    `CHK("status pin", 1'b1, count_status)
    wr(ADDR_CTRL, 8'h05);
    rc(ADDR_CTRL, 8'h07, 8'h00, "forced stop");
    `CHK("status pin low", 1'b0, count_status)
    // Prescaler reload is zero, so only the counter shows motion
    rd(ADDR_CNT, a);
    rd(ADDR_CNT, b);
    `CHK("cnt frozen", a, b)
    $display("test start stop done");
    // Width mode counts only at the selected level
    setup({1'b0, CS_F1, 1'b0, MODE_WIDTH}, 8'h01, 8'h03);
    rd(ADDR_PRE, a);
    cyc(1);
    rd(ADDR_PRE, b);
    `CHK("idle at low, high selected", a, b)
    wr(ADDR_IOC, 8'h00);
    rd(ADDR_PRE, a);
    cyc(1);
    rd(ADDR_PRE, b);
    `CHK("counts at low selected", 1'b1, a !== b)
    // Single pulses of various widths through every filter setting
    for (int i = 0; i < 7; i++) begin
      setup({1'b0, CS_F1, 1'b0, MODE_WIDTH}, {2'b00, ft[i], 4'b0001}, 8'h03);
      hi_len <= 8'(fw[i]);
      lo_len <= 8'hFF;
      run <= 1'b1;
      cyc(fw[i] + 4);
      run <= 1'b0;
      cyc(200);
      rc(ADDR_CTRL, 8'h10, (i % 2 == 0) ? 8'h10 : 8'h00, "pulse accepted");
    end
    wr(ADDR_CTRL, 8'h11);
    rc(ADDR_CTRL, 8'h10, 8'h10, "edge kept");
    wr(ADDR_CTRL, 8'h21);
    rc(ADDR_CTRL, 8'h10, 8'h00, "edge cleared");
    $display("test width done");
    // Period mode: rising versus falling edge selection
    for (int p = 0; p < 2; p++) begin
      setup({1'b0, CS_F1, 1'b0, MODE_PERIOD}, {7'h00, p[0]}, 8'h03);
      hi_len <= 8'h64;
      lo_len <= 8'hFF;
      run <= 1'b1;
      cyc(50);
      rc(ADDR_CTRL, 8'h10, p[0] ? 8'h00 : 8'h10, "edge at rise");
      cyc(80);
      run <= 1'b0;
      rc(ADDR_CTRL, 8'h10, 8'h10, "edge seen");
    end
    // Steady 40-cycle period, then 80 cycles: ten more decrements
    setup({1'b0, CS_F1, 1'b0, MODE_PERIOD}, 8'h00, 8'h03);
    hi_len <= 8'h14;
    lo_len <= 8'h14;
    run <= 1'b1;
    cyc(100);
    // Free the buffer still holding a result from the edge tests
    rd(ADDR_CNT, a);
    n_irq = 0;
    cyc(160);
    `CHK("irq per period", 1'b1, n_irq >= 6 && n_irq <= 10)
    rd(ADDR_CNT, a);
    cyc(100);
    rd(ADDR_CNT, b);
    `CHK("steady result", a, b)
    `CHK("below reload", 1'b1, a < 8'h3F)
    hi_len <= 8'h28;
    lo_len <= 8'h28;
    cyc(300);
    rd(ADDR_CNT, c);
    cyc(150);
    hi_len <= 8'h14;
    lo_len <= 8'h14;
    cyc(200);
    rd(ADDR_CNT, c);
    `CHK("long period kept", a - 8'h0A, c)
    // Zero reload: every reload lands on an underflow
    wr(ADDR_CNT, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    cyc(80);
    rc(ADDR_CTRL, 8'h30, 8'h30, "both flags");
    run <= 1'b0;
    $display("test period done");
    summarize();
  end
endmodule
